// ==== hdl/ir_pulse_distance_codec.sv ====
`timescale 1ns/10ps
// Infrared codec with hex display.
module ir_pulse_distance_codec
    import ir_codec_pkg::*;
#(
    parameter int unsigned BURST_CYC = int'(longint'(CLK_HZ) * T_BURST_NS / 64'd1_000_000_000),
    parameter int unsigned ONE_SPACE_CYC = int'(longint'(CLK_HZ) * T_ONE_SPACE_NS / 64'd1_000_000_000),
    parameter int unsigned LEAD_MARK_CYC = int'(longint'(CLK_HZ) * T_LEAD_MARK_NS / 64'd1_000_000_000),
    parameter int unsigned LEAD_SPACE_CYC = int'(longint'(CLK_HZ) * T_LEAD_SPACE_NS / 64'd1_000_000_000),
    parameter int unsigned BUF_DEPTH = 2
)
(
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Transmit side.
    input wire logic i_transmit_request_button,
    input wire logic [7:0] i_tx_address,
    output logic o_ir_emitter,
    output logic o_tx_busy,
    // Receive side.
    input wire logic i_ir_receiver_n,
    output logic o_rx_frame_valid,
    // Display, active-low segments gfedcba.
    output logic [6:0] o_display_digit_lowest_n,
    output logic [6:0] o_display_digit_1_n,
    output logic [6:0] o_display_digit_2_n,
    output logic [6:0] o_display_digit_3_n,
    output logic [6:0] o_display_digit_4_n,
    output logic [6:0] o_display_digit_highest_n
);

    // Half period of the carrier, rounded down.
    localparam int unsigned CAR_HALF_CYC = CLK_HZ / (2 * CARRIER_HZ);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    // Counters must hold the longest interval.
    if ((LEAD_MARK_CYC + LEAD_MARK_CYC / 4 >= 2 ** CNT_W) || (BURST_CYC < 8)
        || (ONE_SPACE_CYC <= BURST_CYC) || (LEAD_SPACE_CYC <= ONE_SPACE_CYC))
    begin : g_bad_cfg
        $error("ir_pulse_distance_codec: timing counts out of range");
    end

    // Width within a quarter of nominal.
    function automatic logic in_win(input logic [CNT_W-1:0] w, input int unsigned nom);
        in_win = (w >= CNT_W'(nom - nom / 4)) && (w <= CNT_W'(nom + nom / 4));
    endfunction

    // Hex nibble to active-low seven-segment pattern.
    function automatic logic [6:0] seg(input logic [3:0] n);
        unique case (n)
            4'h0: seg = 7'h40;
            4'h1: seg = 7'h79;
            4'h2: seg = 7'h24;
            4'h3: seg = 7'h30;
            4'h4: seg = 7'h19;
            4'h5: seg = 7'h12;
            4'h6: seg = 7'h02;
            4'h7: seg = 7'h78;
            4'h8: seg = 7'h00;
            4'h9: seg = 7'h10;
            4'hA: seg = 7'h08;
            4'hB: seg = 7'h03;
            4'hC: seg = 7'h46;
            4'hD: seg = 7'h21;
            4'hE: seg = 7'h06;
            4'hF: seg = 7'h0E;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pattern source and buffer.

    ir_word_if #(.W(16)) pat_if ();
    ir_word_if #(.W(16)) enc_if ();
    // Button synchroniser.
    logic [1:0] btn_sync_ff;
    // Command value of the next pattern word.
    logic [7:0] pat_cmd_ff;

    // Button is a pin, so it passes two flops first.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            btn_sync_ff <= 2'h0;
        end
        else
        begin
            btn_sync_ff <= {btn_sync_ff[0], i_transmit_request_button};
        end
    end

    // [R11] Continuous pattern supply.
    assign pat_if.valid = btn_sync_ff[1];
    // [R1] Address and command payload.
    assign pat_if.data = {pat_cmd_ff, i_tx_address};

    // Step the command pattern on each accepted word.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pat_cmd_ff <= 8'h00;
        end
        else if (pat_if.valid && pat_if.ready)
        begin
            pat_cmd_ff <= pat_cmd_ff + 8'h01;
        end
    end

    // Buffer; busy encoder stalls the source.
    ir_word_buffer #(.WIDTH(16), .DEPTH(BUF_DEPTH)) u_buf
    (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .in_if(pat_if),
        .out_if(enc_if)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmit encoder.

    tx_state_t tx_state_ff;
    // Cycles left in the current interval.
    logic [CNT_W-1:0] tx_tmr_ff;
    // Index of the bit being sent.
    logic [4:0] tx_bit_ff;
    // Frame bits, sent from bit 0.
    logic [FRAME_BITS-1:0] tx_word_ff;
    // Carrier phase and divider.
    logic car_ph_ff;
    logic [15:0] car_cnt_ff;
    logic tx_mark;
    logic tx_done;

    assign tx_done = (tx_tmr_ff == '0);
    assign tx_mark = (tx_state_ff == TX_LEAD_MARK) || (tx_state_ff == TX_BIT_MARK)
        || (tx_state_ff == TX_END_MARK);
    assign enc_if.ready = (tx_state_ff == TX_IDLE);

    // [R2] Interval timing by clock counting.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_state_ff <= TX_IDLE;
            tx_tmr_ff <= '0;
            tx_bit_ff <= 5'h00;
            tx_word_ff <= '0;
        end
        else
        begin
            unique case (tx_state_ff)
                TX_IDLE:
                begin
                    if (enc_if.valid)
                    begin
                        // [R7] Bytes paired with inverses.
                        // [R19] Address first, LSB first.
                        tx_word_ff <= {~enc_if.data[15:8], enc_if.data[15:8],
                                       ~enc_if.data[7:0], enc_if.data[7:0]};
                        // [R6] Lead burst first.
                        tx_state_ff <= TX_LEAD_MARK;
                        tx_tmr_ff <= CNT_W'(LEAD_MARK_CYC - 1);
                    end
                end
                TX_LEAD_MARK:
                begin
                    if (tx_done)
                    begin
                        tx_state_ff <= TX_LEAD_SPACE;
                        tx_tmr_ff <= CNT_W'(LEAD_SPACE_CYC - 1);
                    end
                    else
                    begin
                        tx_tmr_ff <= tx_tmr_ff - 1'b1;
                    end
                end
                TX_LEAD_SPACE:
                begin
                    if (tx_done)
                    begin
                        tx_state_ff <= TX_BIT_MARK;
                        tx_tmr_ff <= CNT_W'(BURST_CYC - 1);
                        tx_bit_ff <= 5'h00;
                    end
                    else
                    begin
                        tx_tmr_ff <= tx_tmr_ff - 1'b1;
                    end
                end
                TX_BIT_MARK:
                begin
                    if (tx_done)
                    begin
                        tx_state_ff <= TX_BIT_SPACE;
                        // [R5] Long space for one.
                        // [R4] Equal space for zero.
                        tx_tmr_ff <= tx_word_ff[0] ? CNT_W'(ONE_SPACE_CYC - 1) : CNT_W'(BURST_CYC - 1);
                    end
                    else
                    begin
                        tx_tmr_ff <= tx_tmr_ff - 1'b1;
                    end
                end
                TX_BIT_SPACE:
                begin
                    if (tx_done)
                    begin
                        tx_word_ff <= {1'b0, tx_word_ff[FRAME_BITS-1:1]};
                        tx_tmr_ff <= CNT_W'(BURST_CYC - 1);
                        tx_bit_ff <= tx_bit_ff + 5'h01;
                        // [R8] End burst after last bit.
                        tx_state_ff <= (tx_bit_ff == 5'h1F) ? TX_END_MARK : TX_BIT_MARK;
                    end
                    else
                    begin
                        tx_tmr_ff <= tx_tmr_ff - 1'b1;
                    end
                end
                TX_END_MARK:
                begin
                    // [R9] Fixed frame then idle.
                    if (tx_done)
                    begin
                        tx_state_ff <= TX_IDLE;
                    end
                    else
                    begin
                        tx_tmr_ff <= tx_tmr_ff - 1'b1;
                    end
                end
                default:
                begin
                    tx_state_ff <= TX_IDLE;
                end
            endcase
        end
    end

    // Free-running carrier divider.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            car_cnt_ff <= 16'h0000;
            car_ph_ff <= 1'b0;
        end
        else if (car_cnt_ff == 16'(CAR_HALF_CYC - 1))
        begin
            car_cnt_ff <= 16'h0000;
            car_ph_ff <= ~car_ph_ff;
        end
        else
        begin
            car_cnt_ff <= car_cnt_ff + 16'h0001;
        end
    end

    // [R3] Carrier gated into marks.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_ir_emitter <= 1'b0;
            o_tx_busy <= 1'b0;
        end
        else
        begin
            o_ir_emitter <= tx_mark && car_ph_ff;
            o_tx_busy <= (tx_state_ff != TX_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive code detector.

    // Receiver synchroniser and previous level.
    logic [1:0] rx_sync_ff;
    logic rx_prev_ff;
    // Cycles spent at the current level, saturating.
    logic [CNT_W-1:0] rx_cnt_ff;
    logic rx_lvl;
    logic rx_edge;
    logic lead_ok;
    logic guide_ok;
    logic burst_ok;
    logic bit_zero;
    logic bit_one;

    // [R10] Low input is a mark.
    assign rx_lvl = ~rx_sync_ff[1];
    assign rx_edge = (rx_lvl != rx_prev_ff);

    // [R16] Width measurement.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_sync_ff <= 2'h3;
            rx_prev_ff <= 1'b0;
            rx_cnt_ff <= '0;
        end
        else
        begin
            rx_sync_ff <= {rx_sync_ff[0], i_ir_receiver_n};
            rx_prev_ff <= rx_lvl;
            if (rx_edge)
            begin
                rx_cnt_ff <= CNT_W'(1);
            end
            else if (rx_cnt_ff != CNT_MAX)
            begin
                rx_cnt_ff <= rx_cnt_ff + 1'b1;
            end
        end
    end

    // [R12] Lead code checks.
    assign lead_ok = rx_edge && rx_prev_ff && in_win(rx_cnt_ff, LEAD_MARK_CYC);
    assign guide_ok = rx_edge && !rx_prev_ff && in_win(rx_cnt_ff, LEAD_SPACE_CYC);
    assign burst_ok = in_win(rx_cnt_ff, BURST_CYC);
    // [R20] Space classification by midpoint.
    assign bit_one = (rx_cnt_ff > CNT_W'((BURST_CYC + ONE_SPACE_CYC) / 2))
        && (rx_cnt_ff <= CNT_W'(ONE_SPACE_CYC + ONE_SPACE_CYC / 4));
    assign bit_zero = (rx_cnt_ff >= CNT_W'(BURST_CYC - BURST_CYC / 4))
        && (rx_cnt_ff <= CNT_W'((BURST_CYC + ONE_SPACE_CYC) / 2));

    ////////////////////////////////////////////////////////////////////////
    // Receive state machine and shift register.

    rx_state_t rx_state_ff;
    logic [FRAME_BITS-1:0] rx_shift_ff;
    logic [4:0] rx_bit_ff;
    logic [FRAME_BITS-1:0] nxt_word;
    logic rx_last;

    assign nxt_word = {bit_one, rx_shift_ff[FRAME_BITS-1:1]};
    assign rx_last = (rx_state_ff == RX_BIT_COLLECT_STATE) && rx_edge && !rx_prev_ff
        && (bit_one || bit_zero) && (rx_bit_ff == 5'h1F);

    // Sequencing through lead, space and data bits.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_state_ff <= RX_IDLE;
            rx_shift_ff <= '0;
            rx_bit_ff <= 5'h00;
        end
        else
        begin
            unique case (rx_state_ff)
                RX_IDLE:
                begin
                    // [R13] Lead seen.
                    if (lead_ok)
                    begin
                        rx_state_ff <= RX_LEAD_WAIT_STATE;
                    end
                end
                RX_LEAD_WAIT_STATE:
                begin
                    // [R14] Address field starts.
                    if (guide_ok)
                    begin
                        rx_state_ff <= RX_BIT_COLLECT_STATE;
                        rx_bit_ff <= 5'h00;
                    end
                    else if (rx_edge || (rx_cnt_ff == CNT_MAX))
                    begin
                        rx_state_ff <= RX_IDLE;
                    end
                end
                RX_BIT_COLLECT_STATE:
                begin
                    if (rx_cnt_ff == CNT_MAX)
                    begin
                        rx_state_ff <= RX_IDLE;
                    end
                    else if (rx_edge && rx_prev_ff)
                    begin
                        // [R20] Bad burst aborts.
                        if (!burst_ok)
                        begin
                            rx_state_ff <= RX_IDLE;
                        end
                    end
                    else if (rx_edge)
                    begin
                        if (bit_one || bit_zero)
                        begin
                            // [R15] Shift in bit.
                            rx_shift_ff <= nxt_word;
                            rx_bit_ff <= rx_bit_ff + 5'h01;
                            if (rx_last)
                            begin
                                rx_state_ff <= RX_IDLE;
                            end
                        end
                        else
                        begin
                            rx_state_ff <= RX_IDLE;
                        end
                    end
                end
                default:
                begin
                    rx_state_ff <= RX_IDLE;
                end
            endcase
        end
    end

    // [R21] Checked display update.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rx_frame_valid <= 1'b0;
            o_display_digit_lowest_n <= SEG_OFF;
            o_display_digit_1_n <= SEG_OFF;
            o_display_digit_2_n <= SEG_OFF;
            o_display_digit_3_n <= SEG_OFF;
            o_display_digit_4_n <= SEG_OFF;
            o_display_digit_highest_n <= SEG_OFF;
        end
        else
        begin
            o_rx_frame_valid <= rx_last && (nxt_word[23:16] == ~nxt_word[31:24]);
            if (rx_last && (nxt_word[23:16] == ~nxt_word[31:24]))
            begin
                // [R18] Digit placement.
                o_display_digit_lowest_n <= seg(nxt_word[19:16]);
                o_display_digit_1_n <= seg(nxt_word[23:20]);
                o_display_digit_2_n <= seg(nxt_word[3:0]);
                o_display_digit_3_n <= seg(nxt_word[7:4]);
                o_display_digit_4_n <= seg(nxt_word[27:24]);
                o_display_digit_highest_n <= seg(nxt_word[31:28]);
            end
        end
    end

endmodule

// ==== inc/ir_codec_pkg.sv ====
// Notes on behaviour
// [R1] Encoder payload is 8-bit address, 8-bit command.
// [R2] Encoder times come from counting core clocks.
// [R3] Marks are 562.5 us bursts, 38 kHz carrier.
// [R4] Zero is burst plus equal space.
// [R5] One is burst plus 1.6875 ms space.
// [R6] Frame opens with 9 ms burst, 4.5 ms space.
// [R7] Each payload byte is followed by its inverse.
// [R8] Final standard burst ends frame, then idle.
// [R9] Frame length is constant for any payload.
// [R10] Receiver input is active low.
// [R11] Held button keeps pattern frames flowing.
// [R12] Code detector reports lead code checks.
// [R13] Idle moves to lead wait on lead.
// [R14] Lead wait moves to bit collect on space.
// [R15] Received bits shift into display register.
// [R16] Decoder measures widths by counting core clocks.
// [R17] Remote sends lead, key fields, end code.
// [R18] Six digits: inverted data, address, data.
// [R19] Payload 32 bits, bytes LSB first.
// [R20] Long space is one; malformed timing aborts.
// [R21] Display updates only when data check passes.
package ir_codec_pkg;

    // Core clock rate in hertz.
    localparam int unsigned CLK_HZ = 50_000_000;
    // Carrier rate in hertz.
    localparam int unsigned CARRIER_HZ = 38_000;
    // Durations in nanoseconds.
    localparam int unsigned T_BURST_NS = 562_500;
    localparam int unsigned T_ONE_SPACE_NS = 1_687_500;
    localparam int unsigned T_LEAD_MARK_NS = 9_000_000;
    localparam int unsigned T_LEAD_SPACE_NS = 4_500_000;
    // Width of the duration counters.
    localparam int unsigned CNT_W = 20;
    // Payload size in bits.
    localparam int unsigned FRAME_BITS = 32;
    // Blank pattern for an active-low seven-segment digit.
    localparam logic [6:0] SEG_OFF = 7'h7F;

    // Transmit sequencer states.
    typedef enum logic [2:0]
    {
        TX_IDLE = 3'h0,
        TX_LEAD_MARK = 3'h1,
        TX_LEAD_SPACE = 3'h2,
        TX_BIT_MARK = 3'h3,
        TX_BIT_SPACE = 3'h4,
        TX_END_MARK = 3'h5
    } tx_state_t;

    // Receive state machine states.
    typedef enum logic [1:0]
    {
        RX_IDLE = 2'h0,
        RX_LEAD_WAIT_STATE = 2'h1,
        RX_BIT_COLLECT_STATE = 2'h2
    } rx_state_t;

endpackage

// ==== inc/ir_word_if.sv ====
`timescale 1ns/10ps
// Valid/ready word channel.
interface ir_word_if #(parameter int unsigned W = 16) ();
    // Word offered by the source.
    logic valid;
    // Sink accepts the word this cycle.
    logic ready;
    // Word payload.
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== hdl/ir_word_buffer.sv ====
`timescale 1ns/10ps
// Two-entry word FIFO.
module ir_word_buffer
    import ir_codec_pkg::*;
#(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 2
)
(
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Filling side.
    ir_word_if.snk in_if,
    // Draining side.
    ir_word_if.src out_if
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Depth must be a power of two.
    if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0) || (WIDTH < 1))
    begin : g_bad_cfg
        $error("ir_word_buffer: DEPTH must be a power of two of at least 2");
    end

    // Storage for the queued words.
    logic [WIDTH-1:0] mem_ff [DEPTH];
    // Write and read positions.
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    // Number of words held.
    logic [PW:0] count_ff;
    logic push;
    logic pop;

    // Full and empty are exact, taken from the occupancy count.
    assign in_if.ready = (count_ff != (PW+1)'(DEPTH));
    assign out_if.valid = (count_ff != '0);
    assign out_if.data = mem_ff[rd_ptr_ff];
    assign push = in_if.valid && in_if.ready;
    assign pop = out_if.valid && out_if.ready;

    ////////////////////////////////////////////////////////////////////////
    // Storage write; the array needs no reset.
    always_ff @(posedge i_core_clk)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_if.data;
        end
    end

    // Pointer and occupancy upkeep.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            // Simultaneous push and pop leaves the count alone.
            if (push && !pop)
            begin
                count_ff <= count_ff + 1'b1;
            end
            else if (pop && !push)
            begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule

// ==== testbench/ir_codec_properties.sv ====
`timescale 1ns/10ps
// Port checker.
module ir_codec_properties
#(
    parameter int unsigned BURST_CYC = 16,
    parameter int unsigned ONE_SPACE_CYC = 48,
    parameter int unsigned LEAD_MARK_CYC = 256,
    parameter int unsigned LEAD_SPACE_CYC = 128
)
(
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Watched pins.
    input wire logic i_transmit_request_button,
    input wire logic i_ir_receiver_n,
    input wire logic o_ir_emitter,
    input wire logic o_tx_busy,
    input wire logic o_rx_frame_valid,
    input wire logic [6:0] o_display_digit_lowest_n,
    input wire logic [6:0] o_display_digit_highest_n
);
    // Frame length, minimum frame gap.
    localparam int unsigned FRAME = LEAD_MARK_CYC + LEAD_SPACE_CYC + 49 * BURST_CYC + 16 * ONE_SPACE_CYC;
    localparam int unsigned GAP = (LEAD_MARK_CYC + LEAD_SPACE_CYC + 64 * BURST_CYC) * 3 / 4;
    // Busy and gap counters.
    logic [19:0] busy_cnt_ff;
    logic [19:0] gap_cnt_ff;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////
    // Counter upkeep.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            busy_cnt_ff <= '0;
            gap_cnt_ff <= '1;
        end
        else
        begin
            busy_cnt_ff <= o_tx_busy ? busy_cnt_ff + 20'h1 : 20'h0;
            gap_cnt_ff <= o_rx_frame_valid ? 20'h0 : gap_cnt_ff + {19'h0, gap_cnt_ff != '1};
        end
    end
    ////////////////////////////////////////////////////////////
    a_valid_one_cycle: assert property (o_rx_frame_valid |=> !o_rx_frame_valid)
        else $error("pulse too long");
    a_digits_hold: assert property (!o_rx_frame_valid |->
        $stable(o_display_digit_lowest_n) && $stable(o_display_digit_highest_n))
        else $error("digits changed");
    a_emit_in_frame: assert property (o_ir_emitter |-> o_tx_busy || $past(o_tx_busy))
        else $error("emitter while idle");
    a_busy_on_button: assert property ($rose(i_transmit_request_button) && !o_tx_busy
        |-> ##[1:6] o_tx_busy)
        else $error("no frame");
    a_frame_len: assert property ($fell(o_tx_busy) |-> busy_cnt_ff == FRAME)
        else $error("bad length");
    a_back_to_back: assert property ($fell(o_tx_busy) && i_transmit_request_button
        && $past(i_transmit_request_button, 8) |=> o_tx_busy)
        else $error("idle gap too long");
    a_valid_on_mark: assert property (o_rx_frame_valid |-> !$past(i_ir_receiver_n, 2))
        else $error("valid off end burst");
    a_valid_spacing: assert property (o_rx_frame_valid |-> gap_cnt_ff >= GAP)
        else $error("frames too close");
    c_rx_frame: cover property (o_rx_frame_valid);
    c_tx_frame: cover property ($fell(o_tx_busy));
    c_button: cover property ($rose(i_transmit_request_button));
endmodule

// ==== testbench/ir_remote_model.sv ====
`timescale 1ns/10ps
// Remote control at the receiver pin.
module ir_remote_model
#(
    parameter int unsigned BURST_CYC = 16,
    parameter int unsigned ONE_SPACE_CYC = 48,
    parameter int unsigned LEAD_SPACE_CYC = 128
)
(
    input wire logic i_core_clk,
    output logic o_ir_receiver_n
);
    // Idles high.
    initial o_ir_receiver_n = 1'b1;
    // Holds a level for n cycles.
    task automatic hold(input logic lvl, input int unsigned n);
        o_ir_receiver_n = lvl;
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic send(input logic [31:0] w, input int unsigned lead);
        hold(1'b0, lead);
        hold(1'b1, LEAD_SPACE_CYC);
        for (int i = 0; i < 32; i++)
        begin
            hold(1'b0, BURST_CYC);
            hold(1'b1, w[i] ? ONE_SPACE_CYC : BURST_CYC);
        end
        hold(1'b0, BURST_CYC);
        hold(1'b1, 1024);
    endtask
endmodule

// ==== testbench/ir_pulse_distance_codec_tb_top.sv ====
`timescale 1ns/10ps
// Codec bench.
module ir_pulse_distance_codec_tb_top;
    // Shortened timing.
    localparam int unsigned BU = 16;
    localparam int unsigned OS = 48;
    localparam int unsigned LM = 256;
    localparam int unsigned LS = 128;
    localparam int unsigned FRAME = LM + LS + 49 * BU + 16 * OS;
    // Lit segments per digit.
    localparam logic [6:0] SEG [0:15] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
        7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_transmit_request_button = 1'b0;
    logic [7:0] i_tx_address = 8'h00;
    logic i_ir_receiver_n;
    logic o_ir_emitter, o_tx_busy, o_rx_frame_valid;
    logic [6:0] o_display_digit_lowest_n, o_display_digit_1_n, o_display_digit_2_n;
    logic [6:0] o_display_digit_3_n, o_display_digit_4_n, o_display_digit_highest_n;
    int n_errors = 0;
    int tests_run = 0;
    int busy_n = 0;
    int frames = 0;
    // Expected displays.
    logic [41:0] exp_q[$];
    always #5 i_core_clk = ~i_core_clk;
    ////////////////////////////////////////////////////////////
    ir_pulse_distance_codec #(.BURST_CYC(BU), .ONE_SPACE_CYC(OS), .LEAD_MARK_CYC(LM), .LEAD_SPACE_CYC(LS),
        .BUF_DEPTH(2)) i_ir_pulse_distance_codec (.i_core_clk, .i_rst_n, .i_transmit_request_button,
        .i_tx_address, .o_ir_emitter, .o_tx_busy, .i_ir_receiver_n, .o_rx_frame_valid,
        .o_display_digit_lowest_n, .o_display_digit_1_n, .o_display_digit_2_n, .o_display_digit_3_n,
        .o_display_digit_4_n, .o_display_digit_highest_n);
    ir_remote_model #(.BURST_CYC(BU), .ONE_SPACE_CYC(OS), .LEAD_SPACE_CYC(LS)) i_ir_remote_model (
        .i_core_clk, .o_ir_receiver_n(i_ir_receiver_n));
    ////////////////////////////////////////////////////////////
    // Compares one result.
    task automatic cmp(input string what, input logic [41:0] exp, input logic [41:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Verdict.
    task automatic results;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Expected active-low digits.
    function automatic logic [41:0] disp(input logic [7:0] a, input logic [7:0] d);
        return ~{SEG[~d[7:4]], SEG[~d[3:0]], SEG[a[7:4]], SEG[a[3:0]], SEG[d[7:4]], SEG[d[3:0]]};
    endfunction
    ////////////////////////////////////////////////////////////
    // Checks each decoded frame.
    always @(posedge i_core_clk)
    begin
        #2;
        if (o_rx_frame_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp("unexpected frame", 42'h0, 42'h1);
            else
                cmp("display", exp_q.pop_front(), {o_display_digit_highest_n, o_display_digit_4_n,
                    o_display_digit_3_n, o_display_digit_2_n, o_display_digit_1_n, o_display_digit_lowest_n});
        end
    end
    // Frame lengths.
    always @(posedge i_core_clk)
    begin
        #2;
        if (o_tx_busy === 1'b1)
            busy_n++;
        else if (busy_n != 0)
        begin
            cmp("frame length", 42'(FRAME), 42'(busy_n));
            frames++;
            busy_n = 0;
        end
    end
    // Watchdog.
    initial
    begin
        #1_000_000;
        n_errors++;
        results();
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] a;
        logic [7:0] d;
        void'($urandom(32'hD49D));
        repeat (5) @(posedge i_core_clk);
        #1 i_rst_n = 1'b1;
        cmp("reset display", {42{1'b1}}, {o_display_digit_highest_n, o_display_digit_lowest_n, 28'hFFFFFFF});
        i_ir_remote_model.send({8'hA5, 8'h5A, 8'h11, 8'h22}, LM / 2);
        for (int k = 0; k < 6; k++)
        begin
            a = 8'($urandom);
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
            if (k != 2)
                exp_q.push_back(disp(a, d));
            i_ir_remote_model.send({~d ^ {7'h00, k == 2}, d, 8'($urandom), a}, LM);
        end
        cmp("pending frames", 42'h0, 42'(exp_q.size()));
        i_tx_address = 8'($urandom);
        i_transmit_request_button = 1'b1;
        repeat (3 * FRAME) @(posedge i_core_clk);
        #1 i_transmit_request_button = 1'b0;
        repeat (4 * FRAME) @(posedge i_core_clk);
        cmp("busy after release", 42'h0, {41'h0, o_tx_busy});
        cmp("frames sent", 42'h1, {41'h0, frames >= 3});
        results();
    end
endmodule
bind ir_pulse_distance_codec ir_codec_properties #(.BURST_CYC(BURST_CYC), .ONE_SPACE_CYC(ONE_SPACE_CYC),
    .LEAD_MARK_CYC(LEAD_MARK_CYC), .LEAD_SPACE_CYC(LEAD_SPACE_CYC)) i_ir_codec_properties (.i_core_clk,
    .i_rst_n, .i_transmit_request_button, .i_ir_receiver_n, .o_ir_emitter, .o_tx_busy, .o_rx_frame_valid,
    .o_display_digit_lowest_n, .o_display_digit_highest_n);
